/* core/tid_consts.svh */
/*
 Offsets, field positions, reset values and timing counts of the trigger input and delay block.
 Field positions use MSB-first numbering: bit 0 is the word's top bit.
*/
`ifndef TID_CONSTS_SVH
`define TID_CONSTS_SVH

`define TID_ADDR_DLY_CAP   32'hf0f00534
`define TID_ADDR_DLY_STD   32'hf0f00834
`define TID_ADDR_IN_FIRST  32'hf1000300
`define TID_ADDR_IN_SECOND 32'hf1000304
`define TID_ADDR_DLY_FINE  32'hf1000400

`define TID_F_PRESENCE     0
`define TID_F_POLARITY     7
`define TID_F_FUNC_HI      11
`define TID_F_FUNC_LO      15
`define TID_F_LEVEL        31
`define TID_F_ABS          1
`define TID_F_ONE_PUSH     3
`define TID_F_READOUT      4
`define TID_F_CAP_ONOFF    5
`define TID_F_AUTO         6
`define TID_F_MANUAL       7
`define TID_F_MIN_HI       8
`define TID_F_MIN_LO       19
`define TID_F_MAX_HI       20
`define TID_F_MAX_LO       31
`define TID_F_ON           6
`define TID_F_VAL_HI       20
`define TID_F_VAL_LO       31
`define TID_F_US_HI        11
`define TID_F_US_LO        31

`define TID_FN_OFF         5'h00
`define TID_FN_TRIGGER     5'h02
`define TID_FN_SEQ_STEP    5'h06
`define TID_FN_SEQ_RESET   5'h07
`define TID_RST_FN_FIRST   5'h02
`define TID_RST_FN_SECOND  5'h00

`define TID_CAP_ABS        1'b1
`define TID_CAP_ONE_PUSH   1'b0
`define TID_CAP_READOUT    1'b1
`define TID_CAP_ONOFF      1'b1
`define TID_CAP_AUTO       1'b0
`define TID_CAP_MANUAL     1'b1
`define TID_CAP_MIN        12'h000
`define TID_CAP_MAX        12'hfff

`define TID_TRIG_MODE0     4'h0
`define TID_STD_BASE_US    1
`define TID_CLK_PERIOD_NS  8
`define TID_US_NS          1000
`define TID_CYC_PER_US     (`TID_US_NS / `TID_CLK_PERIOD_NS)

`endif

/* core/tid_delay_timer.sv */
/*
 Microsecond delay timer: counts a programmed number of microseconds, then pulses done.
 Assumes clk at 125 MHz and a start that is ignored while busy.
*/
`timescale 1ns/100ps
`default_nettype none
`include "tid_consts.svh"

module tid_delay_timer
  import tid_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        start,
  input  wire logic [20:0] delay_us,
  output var  logic        busy,
  output var  logic        done
);

  localparam logic [6:0] PRE_LAST = 7'(`TID_CYC_PER_US - 1);

  tid_tmr_e    state_q, state_d;
  logic [6:0]  pre_q, pre_d;
  logic [20:0] us_q, us_d;
  logic        done_q, done_d;

  always_comb begin
    state_d = state_q;
    pre_d   = pre_q;
    us_d    = us_q;
    done_d  = 1'b0;
    case (state_q)
      TMR_IDLE: begin
        if (start) begin
          if (delay_us == 21'h000000) begin
            done_d = 1'b1;
          end else begin
            state_d = TMR_RUN;
            pre_d   = 7'h00;
            us_d    = delay_us;
          end
        end
      end
      TMR_RUN: begin
        if (pre_q == PRE_LAST) begin
          pre_d = 7'h00;
          us_d  = us_q - 21'h000001;
          if (us_q == 21'h000001) begin
            done_d  = 1'b1;
            state_d = TMR_IDLE;
          end
        end else begin
          pre_d = pre_q + 7'h01;
        end
      end
      default: state_d = TMR_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= TMR_IDLE;
      pre_q   <= 7'h00;
      us_q    <= 21'h000000;
      done_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      pre_q   <= pre_d;
      us_q    <= us_d;
      done_q  <= done_d;
    end
  end

  assign busy = (state_q == TMR_RUN);
  assign done = done_q;

endmodule : tid_delay_timer

`default_nettype wire

/* core/tid_pkg.sv */
/*
 Types shared by the trigger input and delay block.
 Assumes tid_consts.svh supplies the numeric constants.
*/
package tid_pkg;

  typedef enum logic [0:0] {
    TMR_IDLE,
    TMR_RUN
  } tid_tmr_e;

  // Converts MSB-first bit numbering into a vector index
  function automatic int tid_bit(input int n);
    return 31 - n;
  endfunction : tid_bit

endpackage : tid_pkg

/* core/tid_trigger_top.sv */
/*
 Trigger input conditioning, routing, AND combination and capture delay with its registers.
 Assumes opto_in comes asynchronously from the isolated input stage, all other inputs are
 synchronous to clk, and one register access at a time on the register port.
*/
// Notes on behaviour
// - Polarity bit 0 passes the line unchanged, 1 inverts it.
// - Five-bit function picks off, trigger, sequence step or reset; input one defaults trigger.
// - Read-only line-level bit returns the present input pin state.
// - An open, unconnected input reads 0 in the line-level bit.
// - Input and delay registers show a read-only presence flag set to one.
// - Input stage inverts, so logic negates it before the line-level bit.
// - All trigger-function inputs are ANDed after inversion to form the trigger.
// - Combined trigger starts capture only while external triggering is on.
// - Capability word reports twelve-bit minimum and maximum delay values.
// - Capability word flags absolute, readout, on/off and manual support; its one-push and auto bits read 0.
// - Absolute bit set uses the external absolute value, ignoring the value field.
// - Standard delay enable bit switches delay on or off and reads back.
// - Standard twelve-bit value sets delay in time-base units up to FFFh.
// - Fine delay has its own on/off bit delaying capture after trigger.
// - Fine delay postpones integration by its 21-bit microsecond field.
// - Turning delay on also switches external trigger mode zero on.
// - Delay acts only in external trigger mode zero.
`timescale 1ns/100ps
`default_nettype none
`include "tid_consts.svh"

module tid_trigger_top
  import tid_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [1:0]  opto_in,
  input  wire logic [31:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [31:0] reg_wdata,
  output var  logic [31:0] reg_rdata,
  input  wire logic        ext_trig_enable,
  input  wire logic [3:0]  trig_mode,
  input  wire logic [20:0] abs_delay_us,
  output var  logic        capture_start,
  output var  logic        seq_step,
  output var  logic        seq_reset,
  output var  logic        force_mode0,
  output var  logic        delay_busy
);

  localparam int P_PRES = tid_bit(`TID_F_PRESENCE);
  localparam int P_POL  = tid_bit(`TID_F_POLARITY);
  localparam int P_FHI  = tid_bit(`TID_F_FUNC_HI);
  localparam int P_FLO  = tid_bit(`TID_F_FUNC_LO);
  localparam int P_LVL  = tid_bit(`TID_F_LEVEL);
  localparam int P_ABS  = tid_bit(`TID_F_ABS);
  localparam int P_ON   = tid_bit(`TID_F_ON);
  localparam int P_VHI  = tid_bit(`TID_F_VAL_HI);
  localparam int P_VLO  = tid_bit(`TID_F_VAL_LO);
  localparam int P_UHI  = tid_bit(`TID_F_US_HI);
  localparam int P_ULO  = tid_bit(`TID_F_US_LO);
  localparam int P_MNHI = tid_bit(`TID_F_MIN_HI);
  localparam int P_MNLO = tid_bit(`TID_F_MIN_LO);
  localparam int P_MXHI = tid_bit(`TID_F_MAX_HI);
  localparam int P_MXLO = tid_bit(`TID_F_MAX_LO);

  // Input synchroniser and control state
  logic [1:0]  sync1_q;
  logic [1:0]  sync2_q;
  logic [1:0]  pol_q;
  logic [4:0]  func_q [2];
  logic [1:0]  cond_q;
  logic        comb_q;
  logic        std_abs_q;
  logic        std_on_q;
  logic [11:0] std_val_q;
  logic        fine_on_q;
  logic [20:0] fine_us_q;
  logic [31:0] rdata_q;
  logic        capture_q;
  logic        step_q;
  logic        sreset_q;
  logic        force_q;
  logic        busy_q;

  // Decode
  wire sel_cap  = (reg_addr == `TID_ADDR_DLY_CAP);
  wire sel_std  = (reg_addr == `TID_ADDR_DLY_STD);
  wire sel_in0  = (reg_addr == `TID_ADDR_IN_FIRST);
  wire sel_in1  = (reg_addr == `TID_ADDR_IN_SECOND);
  wire sel_fine = (reg_addr == `TID_ADDR_DLY_FINE);
  wire wr_in0   = reg_wr && sel_in0;
  wire wr_in1   = reg_wr && sel_in1;
  wire wr_std   = reg_wr && sel_std;
  wire wr_fine  = reg_wr && sel_fine;

  // Line conditioning
  wire [1:0] lvl = ~sync2_q;
  wire [1:0] cond = lvl ^ pol_q;
  wire [1:0] is_trig;
  wire [1:0] is_step;
  wire [1:0] is_sreset;
  assign is_trig[0]   = (func_q[0] == `TID_FN_TRIGGER);
  assign is_trig[1]   = (func_q[1] == `TID_FN_TRIGGER);
  assign is_step[0]   = (func_q[0] == `TID_FN_SEQ_STEP);
  assign is_step[1]   = (func_q[1] == `TID_FN_SEQ_STEP);
  assign is_sreset[0] = (func_q[0] == `TID_FN_SEQ_RESET);
  assign is_sreset[1] = (func_q[1] == `TID_FN_SEQ_RESET);
  wire [1:0] cond_rise = cond & ~cond_q;

  // No trigger-configured input means no trigger at all
  wire comb = (|is_trig) && (&(cond | ~is_trig));
  wire trig_edge = comb && !comb_q;
  wire trig_fire = trig_edge && ext_trig_enable;
  wire step_d    = |(cond_rise & is_step);
  wire sreset_d  = |(cond_rise & is_sreset);

  // Delay selection
  wire [20:0] std_us  = 21'(std_val_q) * 21'(`TID_STD_BASE_US);
  wire [20:0] std_sel = std_abs_q ? abs_delay_us : std_us;
  wire [20:0] tmr_us  = fine_on_q ? fine_us_q : std_sel;
  wire dly_active  = fine_on_q || std_on_q;
  wire mode0       = (trig_mode == `TID_TRIG_MODE0);
  wire use_delay   = dly_active && mode0;
  wire tmr_busy;
  wire tmr_done;
  wire tmr_start   = trig_fire && use_delay && !tmr_busy;
  wire fire_direct = trig_fire && !use_delay;
  wire capture_d   = fire_direct || tmr_done;
  wire force_d = (wr_fine && reg_wdata[P_ON]) || (wr_std && reg_wdata[P_ON]);

  tid_delay_timer u_timer (
    .clk      (clk),
    .rst_n    (rst_n),
    .start    (tmr_start),
    .delay_us (tmr_us),
    .busy     (tmr_busy),
    .done     (tmr_done)
  );

  // Read words; unlisted bits stay zero
  function automatic logic [31:0] in_word(input logic pol, input logic [4:0] fn,
                                          input logic lv);
    logic [31:0] w;
    w = 32'h00000000;
    w[P_PRES] = 1'b1;
    w[P_POL]  = pol;
    w[P_FHI:P_FLO] = fn;
    w[P_LVL]  = lv;
    return w;
  endfunction : in_word

  logic [31:0] cap_word;
  logic [31:0] std_word;
  logic [31:0] fine_word;
  always_comb begin
    cap_word = 32'h00000000;
    cap_word[P_PRES] = 1'b1;
    cap_word[tid_bit(`TID_F_ABS)]       = `TID_CAP_ABS;
    cap_word[tid_bit(`TID_F_ONE_PUSH)]  = `TID_CAP_ONE_PUSH;
    cap_word[tid_bit(`TID_F_READOUT)]   = `TID_CAP_READOUT;
    cap_word[tid_bit(`TID_F_CAP_ONOFF)] = `TID_CAP_ONOFF;
    cap_word[tid_bit(`TID_F_AUTO)]      = `TID_CAP_AUTO;
    cap_word[tid_bit(`TID_F_MANUAL)]    = `TID_CAP_MANUAL;
    cap_word[P_MNHI:P_MNLO] = `TID_CAP_MIN;
    cap_word[P_MXHI:P_MXLO] = `TID_CAP_MAX;
    std_word = 32'h00000000;
    std_word[P_PRES] = 1'b1;
    std_word[P_ABS]  = std_abs_q;
    std_word[P_ON]   = std_on_q;
    std_word[P_VHI:P_VLO] = std_val_q;
    fine_word = 32'h00000000;
    fine_word[P_PRES] = 1'b1;
    fine_word[P_ON]   = fine_on_q;
    fine_word[P_UHI:P_ULO] = fine_us_q;
  end

  wire [31:0] rdata_d = sel_in0  ? in_word(pol_q[0], func_q[0], lvl[0]) :
                        sel_in1  ? in_word(pol_q[1], func_q[1], lvl[1]) :
                        sel_cap  ? cap_word :
                        sel_std  ? std_word :
                        sel_fine ? fine_word : 32'h00000000;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      // Idle stage output is high, so no false edge follows reset
      sync1_q <= 2'h3;
      sync2_q <= 2'h3;
    end else begin
      sync1_q <= opto_in;
      sync2_q <= sync1_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pol_q     <= 2'h0;
      func_q[0] <= `TID_RST_FN_FIRST;
      func_q[1] <= `TID_RST_FN_SECOND;
    end else begin
      if (wr_in0) begin
        pol_q[0]  <= reg_wdata[P_POL];
        func_q[0] <= reg_wdata[P_FHI:P_FLO];
      end
      if (wr_in1) begin
        pol_q[1]  <= reg_wdata[P_POL];
        func_q[1] <= reg_wdata[P_FHI:P_FLO];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      std_abs_q <= 1'b0;
      std_on_q  <= 1'b0;
      std_val_q <= 12'h000;
    end else if (wr_std) begin
      std_abs_q <= reg_wdata[P_ABS];
      std_on_q  <= reg_wdata[P_ON];
      std_val_q <= reg_wdata[P_VHI:P_VLO];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fine_on_q <= 1'b0;
      fine_us_q <= 21'h000000;
    end else if (wr_fine) begin
      fine_on_q <= reg_wdata[P_ON];
      fine_us_q <= reg_wdata[P_UHI:P_ULO];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cond_q    <= 2'h0;
      comb_q    <= 1'b0;
      rdata_q   <= 32'h00000000;
      capture_q <= 1'b0;
      step_q    <= 1'b0;
      sreset_q  <= 1'b0;
      force_q   <= 1'b0;
      busy_q    <= 1'b0;
    end else begin
      cond_q    <= cond;
      comb_q    <= comb;
      rdata_q   <= reg_rd ? rdata_d : rdata_q;
      capture_q <= capture_d;
      step_q    <= step_d;
      sreset_q  <= sreset_d;
      force_q   <= force_d;
      busy_q    <= tmr_busy || tmr_start;
    end
  end

  assign reg_rdata     = rdata_q;
  assign capture_start = capture_q;
  assign seq_step      = step_q;
  assign seq_reset     = sreset_q;
  assign force_mode0   = force_q;
  assign delay_busy    = busy_q;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_delay_start;
    tmr_start && (tmr_us == 21'h000001);
  endsequence
  sequence s_capture_after_one_us;
    ##[126:128] capture_q;
  endsequence

  a_line_level_inv: assert property (lvl == ~$past(opto_in, 2))
    else $error("line level not the negated pin");
  a_read_level: assert property (reg_rd && sel_in0 |=> reg_rdata[0] == $past(lvl[0]))
    else $error("line level bit read wrong");
  a_reserved_in_zero: assert property (reg_rd && sel_in1 |=>
      ((reg_rdata & 32'h7ee0fffe) == 32'h00000000) && reg_rdata[31])
    else $error("input register reserved or presence bit wrong");
  a_trig_and: assert property (trig_edge |->
      (!is_trig[0] || cond[0]) && (!is_trig[1] || cond[1]))
    else $error("trigger without all trigger lines high");
  a_capture_needs_ext: assert property (trig_edge && !ext_trig_enable && !tmr_done
      |=> !capture_q)
    else $error("capture without external triggering");
  a_fine_postpone: assert property (tmr_start && fine_on_q && tmr_us != 21'h000000
      |=> !capture_q [*8])
    else $error("capture not postponed by fine delay");
  a_delay_one_us: assert property (s_delay_start |-> s_capture_after_one_us)
    else $error("one microsecond delay timing wrong");
  a_force_mode0: assert property (wr_fine && reg_wdata[P_ON] |=> force_mode0)
    else $error("delay on did not request trigger mode 0");
  a_non_mode0_direct: assert property (trig_fire && !mode0 |=> capture_start)
    else $error("delay applied outside trigger mode 0");
  a_std_onoff: assert property (wr_std |=> std_on_q == $past(reg_wdata[P_ON]))
    else $error("standard delay on/off not stored");
  a_abs_select: assert property (!fine_on_q && std_abs_q |-> tmr_us == abs_delay_us)
    else $error("absolute delay value not used");
  a_cap_range: assert property (reg_rd && sel_cap |=>
      reg_rdata[11:0] == `TID_CAP_MAX && reg_rdata[23:12] == `TID_CAP_MIN)
    else $error("capability range fields wrong");

endmodule : tid_trigger_top

`default_nettype wire

/* tb/test_trigger_input_and_delay.sv */
/*
 Self-checking bench of the trigger input and delay block: registers, routing, AND, delays.
 Assumes the 125 MHz clock and the register timing of the block's hand-over.
*/
`timescale 1ns/100ps
`default_nettype none
`include "tid_consts.svh"

module test_trigger_input_and_delay;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [1:0]  pin_level = 2'b00;
  logic [1:0]  pin_open = 2'b00;
  wire  [1:0]  opto_in;
  logic [31:0] reg_addr = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic        ext_trig_enable = 1'b1;
  logic [3:0]  trig_mode = 4'h0;
  logic [20:0] abs_delay_us = 21'h0;
  logic        capture_start, seq_step, seq_reset, force_mode0, delay_busy;
  int          errors = 0;
  int          n_compared = 0;
  int          cycles = 0;
  logic        f0_seen = 1'b0;
  logic [31:0] w;
  int          c, d;

  always #4 clk = ~clk;

  tid_trig_source src (.pin_level(pin_level), .pin_open(pin_open), .opto_in(opto_in));

  tid_trigger_top dut (.clk(clk), .rst_n(rst_n), .opto_in(opto_in), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .ext_trig_enable(ext_trig_enable), .trig_mode(trig_mode), .abs_delay_us(abs_delay_us),
    .capture_start(capture_start), .seq_step(seq_step), .seq_reset(seq_reset),
    .force_mode0(force_mode0), .delay_busy(delay_busy));

  always @(posedge clk) begin
    if (force_mode0 === 1'b1) f0_seen <= 1'b1;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      $display("mismatch t=%0t timeout", $time);
      summarize();
    end
  end

  task summarize();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("mismatch t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task chk_cyc(input int got, input int lo, input int hi, input string what);
    n_compared++;
    if (got < lo || got > hi) begin
      errors++;
      $display("mismatch t=%0t %s cycles %0d not in %0d..%0d", $time, what, got, lo, hi);
    end
  endtask : chk_cyc

  task wr(input logic [31:0] a, input logic [31:0] dat);
    @(posedge clk) #1;
    reg_addr = a;
    reg_wdata = dat;
    reg_wr = 1'b1;
    @(posedge clk) #1;
    reg_wr = 1'b0;
  endtask : wr

  task rd(input logic [31:0] a, output logic [31:0] dat);
    @(posedge clk) #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk) #1;
    reg_rd = 1'b0;
    dat = reg_rdata;
  endtask : rd

  task rd_chk(input logic [31:0] a, input logic [31:0] exp, input string what);
    logic [31:0] r;
    rd(a, r);
    chk(r, exp, what);
  endtask : rd_chk

  function automatic logic pick(input int s);
    return (s == 0) ? capture_start : (s == 1) ? seq_step : seq_reset;
  endfunction : pick

  // Cycles from a pin change until the chosen pulse; -1 if none within lim
  task meas(input int sel, input logic [1:0] pins, input int lim, output int cyc);
    cyc = -1;
    @(posedge clk) #1;
    pin_level = pins;
    for (int k = 1; k <= lim && cyc < 0; k++) begin
      @(posedge clk) #1;
      if (pick(sel) === 1'b1) cyc = k;
    end
  endtask : meas

  task idle(input string name);
    @(posedge clk) #1;
    pin_level = 2'b00;
    repeat (10) @(posedge clk);
    #1;
    $display("test %s done", name);
  endtask : idle

  function automatic int dly_lo(input int us);
    return us * `TID_CYC_PER_US + 2;
  endfunction : dly_lo

  initial begin
    void'($urandom(32'hdbd7));
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge clk);
    rd_chk(`TID_ADDR_IN_FIRST, 32'h8002_0000, "input1 reset");
    rd_chk(`TID_ADDR_IN_SECOND, 32'h8000_0000, "input2 reset");
    rd_chk(`TID_ADDR_DLY_CAP, 32'hcd00_0fff, "capability");
    rd_chk(`TID_ADDR_DLY_STD, 32'h8000_0000, "std reset");
    rd_chk(`TID_ADDR_DLY_FINE, 32'h8000_0000, "fine reset");
    wr(`TID_ADDR_DLY_CAP, $urandom);
    rd_chk(`TID_ADDR_DLY_CAP, 32'hcd00_0fff, "capability write");
    wr(32'hf1000308, $urandom);
    rd_chk(32'hf1000308, 32'h0, "unmapped");
    idle("reset_values");
    for (int i = 0; i < 2; i++) begin
      w = $urandom;
      wr(i ? `TID_ADDR_IN_SECOND : `TID_ADDR_IN_FIRST, w);
      rd_chk(i ? `TID_ADDR_IN_SECOND : `TID_ADDR_IN_FIRST,
             32'h8000_0000 | (w & 32'h011f_0000), "input mask");
      w = $urandom;
      wr(i ? `TID_ADDR_DLY_STD : `TID_ADDR_DLY_FINE, w & 32'hfdff_ffff);
      rd_chk(i ? `TID_ADDR_DLY_STD : `TID_ADDR_DLY_FINE,
             32'h8000_0000 | (w & (i ? 32'h4000_0fff : 32'h001f_ffff)), "delay mask");
    end
    wr(`TID_ADDR_IN_FIRST, 32'h0002_0000);
    wr(`TID_ADDR_IN_SECOND, 32'h0);
    wr(`TID_ADDR_DLY_STD, 32'h0);
    wr(`TID_ADDR_DLY_FINE, 32'h0);
    pin_level = 2'b01;
    repeat (4) @(posedge clk);
    rd_chk(`TID_ADDR_IN_FIRST, 32'h8002_0001, "level high");
    pin_open = 2'b01;
    repeat (4) @(posedge clk);
    rd_chk(`TID_ADDR_IN_FIRST, 32'h8002_0000, "level open");
    pin_open = 2'b00;
    idle("registers");
    meas(0, 2'b01, 10, c);
    chk_cyc(c, 2, 6, "trigger");
    idle("trigger");
    ext_trig_enable = 1'b0;
    meas(0, 2'b01, 10, c);
    chk_cyc(c, -1, -1, "ext off");
    idle("ext_off");
    ext_trig_enable = 1'b1;
    wr(`TID_ADDR_IN_SECOND, 32'h0002_0000);
    meas(0, 2'b01, 10, c);
    chk_cyc(c, -1, -1, "and one");
    meas(0, 2'b11, 10, c);
    chk_cyc(c, 2, 6, "and both");
    wr(`TID_ADDR_IN_SECOND, 32'h0);
    pin_level = 2'b01;
    wr(`TID_ADDR_IN_FIRST, 32'h0102_0000);
    repeat (6) @(posedge clk);
    meas(0, 2'b00, 10, c);
    chk_cyc(c, 2, 6, "polarity");
    wr(`TID_ADDR_IN_FIRST, 32'h0002_0000);
    idle("and_polarity");
    for (int i = 0; i < 2; i++) begin
      wr(`TID_ADDR_IN_SECOND, i ? 32'h0007_0000 : 32'h0006_0000);
      meas(i + 1, 2'b10, 10, c);
      chk_cyc(c, 2, 6, "sequence");
      idle("sequence");
    end
    wr(`TID_ADDR_IN_SECOND, 32'h0);
    f0_seen = 1'b0;
    wr(`TID_ADDR_DLY_STD, 32'h0200_0002);
    repeat (3) @(posedge clk);
    chk(f0_seen, 1'b1, "mode0 std");
    rd_chk(`TID_ADDR_DLY_STD, 32'h8200_0002, "std on");
    meas(0, 2'b01, 400, c);
    chk_cyc(c, dly_lo(2), dly_lo(2) + 5, "std delay");
    idle("std_delay");
    abs_delay_us = 21'h1;
    wr(`TID_ADDR_DLY_STD, 32'h4200_0fff);
    meas(0, 2'b01, 400, c);
    chk_cyc(c, dly_lo(1), dly_lo(1) + 5, "abs delay");
    idle("abs_delay");
    trig_mode = 4'h1;
    meas(0, 2'b01, 400, c);
    chk_cyc(c, 2, 6, "mode other");
    idle("mode_other");
    trig_mode = 4'h0;
    d = 1 + ($urandom % 3);
    f0_seen = 1'b0;
    wr(`TID_ADDR_DLY_FINE, 32'h0200_0000 | d);
    repeat (3) @(posedge clk);
    chk(f0_seen, 1'b1, "mode0 fine");
    rd_chk(`TID_ADDR_DLY_FINE, 32'h8200_0000 | d, "fine on");
    meas(0, 2'b01, 600, c);
    chk_cyc(c, dly_lo(d), dly_lo(d) + 5, "fine delay");
    idle("fine_delay");
    @(posedge clk) #1;
    pin_level = 2'b01;
    repeat (6) @(posedge clk);
    #1;
    chk(delay_busy, 1'b1, "busy during delay");
    repeat (130 * d) @(posedge clk);
    #1;
    chk(delay_busy, 1'b0, "busy after delay");
    idle("delay_busy");
    wr(`TID_ADDR_DLY_FINE, 32'h0);
    wr(`TID_ADDR_DLY_STD, 32'h0000_0002);
    meas(0, 2'b01, 400, c);
    chk_cyc(c, 2, 6, "delay off");
    idle("delay_off");
    summarize();
  end
endmodule : test_trigger_input_and_delay

`default_nettype wire

/* tb/tid_trig_source.sv */
/*
 External trigger source on the two camera input pins, seen through the isolating stage.
 Assumes the bench sets pin levels and open pins off the clock edge.
*/
`timescale 1ns/100ps
`default_nettype none

module tid_trig_source (
  input  wire logic [1:0] pin_level,
  input  wire logic [1:0] pin_open,
  output var  logic [1:0] opto_in
);
  // Stage inverts; an open pin leaves its output high
  always_comb opto_in = pin_open | ~pin_level;
endmodule : tid_trig_source

`default_nettype wire
